// >>> common/ufm_pkg.sv
// Shared constants for the mode and event-flag command block.
// Assumes one 100 MHz clock and a byte-wide command port from the controller.
package ufm_pkg;

    // ************************************************
    // Command codes
    // ************************************************
    localparam logic [7:0] CMD_SET_MODE   = 8'hF3;  // One config byte follows
    localparam logic [7:0] CMD_READ_FLAGS = 8'hF4;  // Two flag bytes follow
    localparam logic [7:0] CMD_SEL_CLR_LO = 8'h40;  // Select and acknowledge, index 0
    localparam logic [7:0] CMD_SEL_CLR_HI = 8'h4B;  // Select and acknowledge, index 11
    localparam logic [7:0] CMD_HUB_STATUS = 8'hFE;  // Hub status read
    localparam logic [7:0] CMD_PORT_LO    = 8'hE0;  // Function 1 port status
    localparam logic [7:0] CMD_PORT_HI    = 8'hE2;  // Function 3 port status

    // ************************************************
    // Configuration byte layout and reset
    // ************************************************
    localparam int         CFG_WAKE_KICK  = 6;      // Clock kick on bus activity
    localparam int         CFG_TEXT_DESC  = 5;      // String descriptor
    localparam int         CFG_KEY_WAKE   = 4;      // Key press remote wake
    localparam int         CFG_KEEP_OSC   = 3;      // Clocks run in suspend
    localparam int         CFG_PULLDOWN   = 2;      // Downstream pull-downs
    localparam int         CFG_REFUSAL    = 0;      // Flag on NAK
    localparam logic [7:0] CFG_WRITE_MASK = 8'h7D;  // Reserved bits 7 and 1 dropped
    localparam logic [7:0] CFG_RESET      = 8'h01;  // Only NAK reporting on

    // ************************************************
    // Event flag layout and reset
    // ************************************************
    localparam int          NUM_EP         = 12;     // Endpoint flags 11:0
    localparam int          FLAG_FUNC_BASE = 12;     // Function change flags 14:12
    localparam int          FLAG_HUB       = 15;     // Hub change flag
    localparam logic [15:0] FLAGS_RESET    = 16'h0000;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_MHZ      = 100;                  // System clock rate
    localparam int WAKE_TIME_US = 2000;                 // Clock kick length, 2 ms
    localparam int WAKE_CYCLES  = WAKE_TIME_US * CLK_MHZ;

    // Command phase
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_CFG  = 2'b01,
        PH_READ = 2'b10
    } ufm_phase_type;

endpackage

// >>> design/ufm_wake_timer.sv
// Fixed-length activity window started by a one-cycle pulse.
// Assumes the start pulse is synchronous to the system clock.
module ufm_wake_timer #(
    parameter int CYCLES = ufm_pkg::WAKE_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    // Control
    input  wire logic start_in,
    output logic      active_out
);

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic [17:0] cnt;   // Cycles still to run
    } ufm_timer_type;

    ufm_timer_type st_r;    // Registered state
    ufm_timer_type st_nxt;  // Next state

    // Reload on start, otherwise count down to zero
    always_comb begin
        st_nxt = st_r;
        if (start_in) begin
            st_nxt.cnt = 18'(CYCLES);
        end else if (st_r.cnt != 18'h00000) begin
            st_nxt.cnt = st_r.cnt - 18'h00001;
        end
    end

    // Synchronous reset
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Window open while counting
    assign active_out = (st_r.cnt != 18'h00000);

endmodule // ufm_wake_timer

// >>> design/ufm_mode_irq.sv
// Configuration byte and 16-bit event flag register behind the command port.
// Assumes the controller issues command and data strobes synchronous to sys_clk_in.
//
// Notes on behaviour
// - F3 takes exactly one following config byte
// - Bit 6: bus activity in suspend runs clock 2ms
// - Bit 5 enables the default string descriptor
// - Bit 4 lets function 1 keys wake host
// - Bit 3 keeps clocks running in suspend
// - Bit 2 connects downstream pull-downs
// - Bit 0 flags NAKs; otherwise successes only
// - F4 returns flags low byte then high
// - Hub endpoints never raise controller flags
// - Bits 11:0 are endpoint events, four per function
// - Bits 14:12 function changes, 15 hub change
// - Hub status read clears bit 15
// - Port status read clears its own bit
// - Select-acknowledge clears only its endpoint flag
// - Codes 40-4B, then one status byte read
// - NAK status bit: control endpoints, enabled only
module ufm_mode_irq #(
    parameter int WAKE_CYCLES = ufm_pkg::WAKE_CYCLES
) (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // Command port from the controller
    input  wire logic        cmd_wr_in,
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic        data_wr_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        data_rd_in,
    output logic      [7:0]  rd_data_out,
    // Endpoint and status events
    input  wire logic [11:0] ep_ack_in,
    input  wire logic [11:0] ep_nak_in,
    input  wire logic [47:0] ep_buf_status_in,
    input  wire logic [2:0]  func_state_chg_in,
    input  wire logic        hub_state_chg_in,
    input  wire logic [7:0]  hub_status_in,
    input  wire logic [23:0] port_status_in,
    // Power and bus events
    input  wire logic        suspend_in,
    input  wire logic        bus_transition_in,
    input  wire logic        key_press_in,
    // Feature controls and interrupt
    output logic             text_descriptor_allow_out,
    output logic             downstream_pulldown_connect_out,
    output logic             internal_clock_run_out,
    output logic             key_host_wake_out,
    output logic             irq_out
);

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        ufm_pkg::ufm_phase_type phase;     // Command phase
        logic [7:0]             cmd;       // Last command code
        logic                   byte_idx;  // Read byte within a command
        logic [7:0]             cfg;       // operating_configuration
        logic [15:0]            flags;     // event_source_flags
        logic [11:0]            refusal;   // refusal_sent_flag per endpoint
        logic [7:0]             rd_data;   // Read data register
        logic                   wake;      // Key wake request
    } ufm_state_type;

    ufm_state_type st_r;     // Registered state
    ufm_state_type st_nxt;   // Next state
    logic [11:0]   ep_set;   // Endpoint flag set terms
    logic [11:0]   ep_clr;   // Endpoint flag clear terms
    logic          kick;     // Start of clock kick
    logic          kick_on;  // Clock kick window open

    // ************************************************
    // Per-endpoint set and clear terms
    // ************************************************
    // Only function endpoints appear here; hub endpoints have no input at all
    genvar g;
    generate
        for (g = 0; g < ufm_pkg::NUM_EP; g++) begin : g_ep
            // Success always flags, NAK only when reporting is on
            assign ep_set[g] = ep_ack_in[g]
                             | (ep_nak_in[g] & st_r.cfg[ufm_pkg::CFG_REFUSAL]);
            // Acknowledge command clears its own endpoint only
            assign ep_clr[g] = cmd_wr_in
                             && (cmd_code_in == ufm_pkg::CMD_SEL_CLR_LO + 8'(g));
        end
    endgenerate

    // ************************************************
    // Command decode and flag update
    // ************************************************
    always_comb begin
        logic [15:0] set_v;
        logic [15:0] clr_v;
        logic [7:0]  st_b;
        logic [3:0]  idx;
        set_v  = 16'h0000;
        clr_v  = 16'h0000;
        st_b   = 8'h00;
        idx    = 4'h0;
        st_nxt = st_r;
        st_nxt.wake = 1'b0;
        // Event sources; hub endpoint traffic never reaches here
        set_v[11:0]  = ep_set;
        set_v[14:12] = func_state_chg_in;
        set_v[15]    = hub_state_chg_in;
        clr_v[11:0]  = ep_clr;
        // New command restarts byte sequencing
        if (cmd_wr_in) begin
            st_nxt.cmd      = cmd_code_in;
            st_nxt.byte_idx = 1'b0;
            if (cmd_code_in == ufm_pkg::CMD_SET_MODE) begin
                st_nxt.phase = ufm_pkg::PH_CFG;
            end else begin
                st_nxt.phase = ufm_pkg::PH_READ;
            end
        end else begin
            unique case (st_r.phase)
                // Exactly one byte is taken, later writes are ignored
                ufm_pkg::PH_CFG: begin
                    if (data_wr_in) begin
                        st_nxt.cfg   = data_in & ufm_pkg::CFG_WRITE_MASK;
                        st_nxt.phase = ufm_pkg::PH_IDLE;
                    end
                end
                // Read bytes for the last command
                ufm_pkg::PH_READ: begin
                    if (data_rd_in) begin
                        st_nxt.byte_idx = 1'b1;
                        if (st_r.cmd == ufm_pkg::CMD_READ_FLAGS) begin
                            // Low byte first, then high
                            st_nxt.rd_data = st_r.byte_idx ? st_r.flags[15:8]
                                                           : st_r.flags[7:0];
                        end else if (st_r.cmd >= ufm_pkg::CMD_SEL_CLR_LO
                                     && st_r.cmd <= ufm_pkg::CMD_SEL_CLR_HI) begin
                            idx  = st_r.cmd[3:0];
                            st_b = {3'h0, 1'b0, ep_buf_status_in[idx*4 +: 4]};
                            // NAK bit only for control endpoints, only when enabled
                            st_b[4] = st_r.refusal[idx] && (idx[1] == 1'b0)
                                    && st_r.cfg[ufm_pkg::CFG_REFUSAL];
                            st_nxt.rd_data = st_b;
                        end else if (st_r.cmd == ufm_pkg::CMD_HUB_STATUS) begin
                            st_nxt.rd_data = hub_status_in;
                            clr_v[ufm_pkg::FLAG_HUB] = 1'b1;
                        end else if (st_r.cmd >= ufm_pkg::CMD_PORT_LO
                                     && st_r.cmd <= ufm_pkg::CMD_PORT_HI) begin
                            idx = {2'h0, st_r.cmd[1:0]};
                            st_nxt.rd_data = port_status_in[idx*8 +: 8];
                            clr_v[ufm_pkg::FLAG_FUNC_BASE + 32'(idx)] = 1'b1;
                        end else begin
                            // Commands owned elsewhere read as zero here
                            st_nxt.rd_data = 8'h00;
                        end
                    end
                end
                default: begin
                    st_nxt.phase = ufm_pkg::PH_IDLE;
                end
            endcase
        end
        // A set in the same cycle as its clear wins
        st_nxt.flags = (st_r.flags & ~clr_v) | set_v;
        // NAK indication cleared by a successful handshake
        st_nxt.refusal = (st_r.refusal & ~ep_ack_in)
                       | (ep_nak_in & {12{st_r.cfg[ufm_pkg::CFG_REFUSAL]}});
        // Function 1 key press wakes the host only when allowed
        st_nxt.wake = suspend_in && key_press_in
                   && st_r.cfg[ufm_pkg::CFG_KEY_WAKE];
    end

    // Synchronous reset to documented defaults
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st_r.phase    <= ufm_pkg::PH_IDLE;
            st_r.cmd      <= 8'h00;
            st_r.byte_idx <= 1'b0;
            st_r.cfg      <= ufm_pkg::CFG_RESET;
            st_r.flags    <= ufm_pkg::FLAGS_RESET;
            st_r.refusal  <= 12'h000;
            st_r.rd_data  <= 8'h00;
            st_r.wake     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************
    // Suspend clock kick
    // ************************************************
    // Bus activity during suspend opens a fixed window without resume signalling
    assign kick = suspend_in && bus_transition_in
               && st_r.cfg[ufm_pkg::CFG_WAKE_KICK];

    ufm_wake_timer #(
        .CYCLES(WAKE_CYCLES)
    ) u_wake (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .start_in   (kick),
        .active_out (kick_on)
    );

    // ************************************************
    // Outputs
    // ************************************************
    assign rd_data_out                     = st_r.rd_data;
    assign text_descriptor_allow_out       = st_r.cfg[ufm_pkg::CFG_TEXT_DESC];
    assign downstream_pulldown_connect_out = st_r.cfg[ufm_pkg::CFG_PULLDOWN];
    // Clock, oscillator and PLL stop in suspend unless kept or kicked
    assign internal_clock_run_out = !suspend_in
                                  || st_r.cfg[ufm_pkg::CFG_KEEP_OSC]
                                  || kick_on;
    assign key_host_wake_out = st_r.wake;
    // Level interrupt, released once every flag is clear
    assign irq_out = |st_r.flags;

endmodule // ufm_mode_irq

// >>> dv/ufm_mode_irq_assertions.sv
// Concurrent checks on the mode and event-flag block ports.
// Assumes binding to ufm_mode_irq; one clock, synchronous active-low reset.
module ufm_mode_irq_chk #(
    parameter int WAKE_CYCLES = 20
) (
    // Clock, reset and command port
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic        cmd_wr_in,
    input wire logic [7:0]  cmd_code_in,
    input wire logic        data_wr_in,
    input wire logic [7:0]  data_in,
    // Events
    input wire logic [11:0] ep_ack_in,
    input wire logic [11:0] ep_nak_in,
    input wire logic [2:0]  func_state_chg_in,
    input wire logic        hub_state_chg_in,
    input wire logic        suspend_in,
    input wire logic        bus_transition_in,
    input wire logic        key_press_in,
    // Outputs watched
    input wire logic        text_descriptor_allow_out,
    input wire logic        downstream_pulldown_connect_out,
    input wire logic        internal_clock_run_out,
    input wire logic        key_host_wake_out,
    input wire logic        irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************
    // Shadow of the stored config byte
    // ************************************************
    logic [7:0] cfg_r;  // Expected config
    logic       arm_r;  // Set-mode waiting for its byte
    // Strobes that coincide with a command are dropped, as in the block
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cfg_r <= 8'h01;
            arm_r <= 1'b0;
        end else if (cmd_wr_in) begin
            arm_r <= (cmd_code_in == 8'hF3);
        end else if (data_wr_in && arm_r) begin
            cfg_r <= data_in & 8'h7D;
            arm_r <= 1'b0;
        end
    end
    // Shadow of the clock kick window, reloaded by every qualifying transition
    int win_r;  // Kick cycles still expected
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            win_r <= 0;
        end else if (suspend_in && bus_transition_in && cfg_r[6]) begin
            win_r <= WAKE_CYCLES;
        end else if (win_r != 0) begin
            win_r <= win_r - 1;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_cfg_pulldown: assert property (
        arm_r && data_wr_in && !cmd_wr_in |=> downstream_pulldown_connect_out == $past(data_in[2]))
        else $error("pull-down output differs from written byte");
    a_text_hold: assert property (text_descriptor_allow_out == cfg_r[5])
        else $error("string descriptor enable differs from config");
    a_keep_osc: assert property (suspend_in && cfg_r[3] |-> internal_clock_run_out)
        else $error("clock stopped in suspend with keep set");
    a_kick_window: assert property (
        suspend_in && bus_transition_in && cfg_r[6] |=> internal_clock_run_out [*8])
        else $error("clock kick window too short");
    a_kick_length: assert property (
        suspend_in && !cfg_r[3] |-> internal_clock_run_out == (win_r != 0))
        else $error("clock kick window length wrong");
    a_key_wake: assert property ($past(rst_n_in) |->
        key_host_wake_out == $past(suspend_in && key_press_in && cfg_r[4]))
        else $error("key wake pulse wrong");
    a_nak_masked: assert property (!irq_out && !cfg_r[0] && !hub_state_chg_in &&
        ep_ack_in == 12'h000 && func_state_chg_in == 3'b000 |=> !irq_out)
        else $error("flag raised by masked refusal");
    a_nak_flag: assert property ((|ep_nak_in) && cfg_r[0] |=> irq_out)
        else $error("refusal not flagged");
    a_event_irq: assert property (
        (|ep_ack_in) || (|func_state_chg_in) || hub_state_chg_in |=> irq_out)
        else $error("event did not raise interrupt");
    a_reset_state: assert property ($rose(rst_n_in) |->
        !irq_out && !text_descriptor_allow_out && !downstream_pulldown_connect_out)
        else $error("outputs not at reset values");
    c_cfg_write: cover property (arm_r && data_wr_in);
    c_kick: cover property (suspend_in && bus_transition_in && cfg_r[6]);
    c_key: cover property (key_host_wake_out);
endmodule // ufm_mode_irq_chk

bind ufm_mode_irq ufm_mode_irq_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
    .sys_clk_in, .rst_n_in, .cmd_wr_in, .cmd_code_in, .data_wr_in, .data_in,
    .ep_ack_in, .ep_nak_in, .func_state_chg_in, .hub_state_chg_in, .suspend_in,
    .bus_transition_in, .key_press_in, .text_descriptor_allow_out,
    .downstream_pulldown_connect_out, .internal_clock_run_out, .key_host_wake_out, .irq_out
);

// >>> dv/ufm_ctrl_model.sv
// Controller model: one strobe per operation, driven on falling edges.
// Assumes the block samples strobes on the rising edge between.
module ufm_ctrl_model (
    // Clock
    input  wire logic       sys_clk_in,
    // Command port
    output logic            cmd_wr_out,
    output logic      [7:0] cmd_code_out,
    output logic            data_wr_out,
    output logic      [7:0] data_out,
    output logic            data_rd_out,
    input  wire logic [7:0] rd_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cmd_wr_out, cmd_code_out, data_wr_out, data_out, data_rd_out} = '0;
    // Released lines show the inverse so stale values never match by chance
    task automatic put_cmd(input logic [7:0] code);
        @(negedge sys_clk_in);
        cmd_wr_out   = 1'b1;
        cmd_code_out = code;
        @(negedge sys_clk_in);
        cmd_wr_out   = 1'b0;
        cmd_code_out = ~code;
    endtask
    // Exactly one byte per call; reserved bit 1 always sent low
    task automatic put_data(input logic [7:0] b);
        @(negedge sys_clk_in);
        data_wr_out = 1'b1;
        data_out    = b & 8'hFD;
        @(negedge sys_clk_in);
        data_wr_out = 1'b0;
        data_out    = ~data_out;
    endtask
    // Answer is registered at the sampling edge, taken at the next fall
    task automatic get_byte(output logic [7:0] b);
        @(negedge sys_clk_in);
        data_rd_out = 1'b1;
        @(negedge sys_clk_in);
        data_rd_out = 1'b0;
        b           = rd_data_in;
    endtask
endmodule // ufm_ctrl_model

// >>> dv/ufm_mode_irq_tb.sv
// Self-checking bench for the mode and event-flag block.
// Assumes ufm_pkg is compiled first; controller model drives the command port.
module ufm_mode_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAKE = 20;  // Short kick window keeps the run brief
    logic        sys_clk_in, rst_n_in, cmd_wr, data_wr, data_rd;
    logic [7:0]  cmd_code, data, rd_data, b;
    logic [11:0] ep_ack, ep_nak;
    logic [2:0]  fchg;
    logic        hchg, susp, bus_tr, key, text_o, pd_o, run_o, wake_o, irq_o;
    logic [15:0] f;
    logic [47:0] bufs  = 48'hFEDCBA987654;  // Buffer status nibbles
    logic [23:0] pstat = 24'h3C5A96;        // Port status bytes
    int          mismatches, total_checks, n, j;
    ufm_mode_irq #(.WAKE_CYCLES(WAKE)) u_dut (.sys_clk_in, .rst_n_in, .cmd_wr_in(cmd_wr),
        .cmd_code_in(cmd_code), .data_wr_in(data_wr), .data_in(data), .data_rd_in(data_rd),
        .rd_data_out(rd_data), .ep_ack_in(ep_ack), .ep_nak_in(ep_nak),
        .ep_buf_status_in(bufs), .func_state_chg_in(fchg), .hub_state_chg_in(hchg),
        .hub_status_in(8'hA5), .port_status_in(pstat), .suspend_in(susp),
        .bus_transition_in(bus_tr), .key_press_in(key), .text_descriptor_allow_out(text_o),
        .downstream_pulldown_connect_out(pd_o), .internal_clock_run_out(run_o),
        .key_host_wake_out(wake_o), .irq_out(irq_o));
    ufm_ctrl_model u_ctl (.sys_clk_in, .cmd_wr_out(cmd_wr), .cmd_code_out(cmd_code),
        .data_wr_out(data_wr), .data_out(data), .data_rd_out(data_rd), .rd_data_in(rd_data));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One-cycle event pulse: {hub change, bus activity, key}
    task automatic ev(input logic [11:0] a, input logic [11:0] k, input logic [2:0] fc,
                      input logic [2:0] hbk);
        @(negedge sys_clk_in);
        {ep_ack, ep_nak, fchg, hchg, bus_tr, key} = {a, k, fc, hbk};
        @(negedge sys_clk_in);
        {ep_ack, ep_nak, fchg, hchg, bus_tr, key} = '0;
    endtask
    task automatic rd_flags(output logic [15:0] v);
        logic [7:0] lo;
        u_ctl.put_cmd(ufm_pkg::CMD_READ_FLAGS);
        u_ctl.get_byte(lo);
        u_ctl.get_byte(v[15:8]);
        v[7:0] = lo;
    endtask
    task automatic set_mode(input logic [7:0] m);
        u_ctl.put_cmd(ufm_pkg::CMD_SET_MODE);
        u_ctl.put_data(m);
    endtask
    initial begin
        {rst_n_in, ep_ack, ep_nak, fchg, hchg, susp, bus_tr, key} = '0;
        repeat (10) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        chk(16'({text_o, pd_o, irq_o}), 16'h0000);
        rd_flags(f);
        chk(f, 16'h0000);
        set_mode(8'h24);
        u_ctl.put_data(8'h00);
        chk(16'({text_o, pd_o}), 16'h0003);
        $display("test config done");
        set_mode(8'h00);
        ev(12'h000, 12'h002, 3'b000, 3'b000);
        chk(16'(irq_o), 16'h0000);
        set_mode(8'h01);
        ev(12'h000, 12'h005, 3'b000, 3'b000);
        rd_flags(f);
        chk(f, 16'h0005);
        u_ctl.put_cmd(8'h40);
        u_ctl.get_byte(b);
        chk(16'(b), 16'({4'h1, bufs[3:0]}));
        u_ctl.put_cmd(8'h42);
        u_ctl.get_byte(b);
        chk(16'(b), 16'(bufs[11:8]));
        chk(16'(irq_o), 16'h0000);
        $display("test refusal done");
        for (int i = 0; i < 12; i++) begin
            j = (i + 5) % 12;
            ev((12'h001 << i) | (12'h001 << j), 12'h000, 3'b000, 3'b000);
            chk(16'(irq_o), 16'h0001);
            rd_flags(f);
            chk(f, (16'h0001 << i) | (16'h0001 << j));
            u_ctl.put_cmd(8'h40 + 8'(i));
            u_ctl.get_byte(b);
            chk(16'(b), 16'(bufs[4*i +: 4]));
            rd_flags(f);
            chk(f, 16'h0001 << j);
            u_ctl.put_cmd(8'h40 + 8'(j));
            u_ctl.get_byte(b);
            chk(16'(b), 16'(bufs[4*j +: 4]));
            chk(16'(irq_o), 16'h0000);
        end
        $display("test endpoints done");
        ev(12'h000, 12'h000, 3'b111, 3'b100);
        rd_flags(f);
        chk(f, 16'hF000);
        u_ctl.put_cmd(ufm_pkg::CMD_HUB_STATUS);
        u_ctl.get_byte(b);
        chk(16'(b), 16'h00A5);
        rd_flags(f);
        chk(f, 16'h7000);
        for (int p = 0; p < 3; p++) begin
            u_ctl.put_cmd(8'hE0 + 8'(p));
            u_ctl.get_byte(b);
            chk(16'(b), 16'(pstat[8*p +: 8]));
            rd_flags(f);
            chk(f, 16'h7000 & (16'hE000 << p));
        end
        $display("test status done");
        set_mode(8'h40);
        susp = 1'b1;
        @(negedge sys_clk_in);
        chk(16'(run_o), 16'h0000);
        ev(12'h000, 12'h000, 3'b000, 3'b010);
        n = 0;
        while (run_o === 1'b1 && n < 100) begin
            n++;
            @(negedge sys_clk_in);
        end
        if (n == 100) begin
            mismatches++;
            complete_run();
        end
        chk(16'(n), 16'(WAKE));
        set_mode(8'h08);
        chk(16'(run_o), 16'h0001);
        ev(12'h000, 12'h000, 3'b000, 3'b001);
        chk(16'(wake_o), 16'h0000);
        set_mode(8'h10);
        ev(12'h000, 12'h000, 3'b000, 3'b001);
        chk(16'(wake_o), 16'h0001);
        $display("test power done");
        complete_run();
    end
endmodule // ufm_mode_irq_tb
